/* File: logic/icdt_capture_unit.sv */
// Input capture unit with its own 16-bit counter and 4-entry FIFO.
// Assumes a synchronous register port and single-cycle source pulses.
//
// Summary of operation
// - Modes: off, both, falling, rising edges
// - Modes four/sixteen rising prescale; 110 disabled
// - Mode 111: rising wake only in sleep/idle
// - Both-edge mode ignores captures-per-interrupt
// - Interrupt every first to fourth capture
// - Not-empty flag tracks stored captures
// - Overflow flag owned by hardware only
// - Time base field selects counter clock
// - Halt-in-idle bit stops unit in idle
// - Cascade bit joins odd/even pair
// - Trigger bit picks trigger or sync
// - Trigger status set by hardware; clear holds counter
// - Source field selects sync/trigger source
// - Sync operation held until source enabled
// - Even module runs synced with odd
// - Odd module settings govern the pair
// - Pair read low odd, high even
// - Capture FIFO is four entries deep
// - Free counter wraps; captures store its value
// - Sync source event resets counter
// - Source none with trigger: software trigger
//
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module icdt_capture_unit
    import icdt_pkg::*;
#(
    parameter logic IS_EVEN = 1'b0
)
(
    input  wire logic        i_clock,
    input  wire logic        i_resetn,
    input  wire logic [1:0]  i_addr,
    input  wire logic [15:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    input  wire logic        i_capture_pin,
    input  wire logic [4:0]  i_time_base_ticks,
    input  wire logic [31:0] i_sync_events,
    input  wire logic [31:0] i_source_enabled,
    input  wire logic        i_cpu_idle,
    input  wire logic        i_cpu_sleep,
    input  wire logic        i_pair_wrap,
    input  wire logic        i_pair_capture,
    input  wire logic        i_pair_run,
    output logic      [15:0] o_rdata,
    output logic             o_capture_irq,
    output logic             o_wake_irq,
    output logic             o_wrap,
    output logic             o_capture,
    output logic             o_run
);
    icdt_cfg1_t  cfg1_r, cfg1_nxt;
    icdt_cfg2_t  cfg2_r, cfg2_nxt;
    logic        tstat_r, tstat_nxt;
    logic [15:0] cnt_r, cnt_nxt;
    logic [15:0] mem_r [4];
    logic [15:0] mem_nxt [4];
    logic [1:0]  wp_r, wp_nxt, rp_r, rp_nxt;
    logic [2:0]  fill_r, fill_nxt;
    logic        ov_r, ov_nxt;
    logic [1:0]  ici_cnt_r, ici_cnt_nxt;
    logic [15:0] rdata_r, rdata_nxt;
    logic        irq_r, irq_nxt, wake_r, wake_nxt;
    logic        wrap_r, wrap_nxt, capo_r, capo_nxt, run_r;
    logic        slave, halted, active, edge_cap, edge_rise, cap_evt;
    logic        tick, src_evt, src_on, trig_mode, hw_set, run;
    logic        push, pop, full, ovf, store;

    // -------------------------------------------------------------
    // Edge detection
    // -------------------------------------------------------------
    icdt_edge u_edge (
        .i_clock   (i_clock),
        .i_resetn  (i_resetn),
        .i_pin     (i_capture_pin),
        .i_mode    (cfg1_r.mode),
        .i_enable  (active & ~slave),
        .o_capture (edge_cap),
        .o_rise    (edge_rise)
    );

    // -------------------------------------------------------------
    // Mode, time base and source decode
    // -------------------------------------------------------------
    // Even half of a pair takes its clock, edges and run from the odd half
    always_comb begin
        slave   = IS_EVEN & cfg2_r.cascade;
        halted  = i_cpu_sleep | (i_cpu_idle & cfg1_r.sidl);
        active  = ~halted & (cfg1_r.mode != MODE_OFF) & (cfg1_r.mode != MODE_UNUSED)
                  & (cfg1_r.mode != MODE_WAKE);
        cap_evt = slave ? i_pair_capture : edge_cap;
        case (cfg1_r.tsel)
            TSEL_SYSCLK: tick = 1'b1;
            TSEL_RSV_A, TSEL_RSV_B: tick = 1'b0;
            default: tick = i_time_base_ticks[cfg1_r.tsel];
        endcase
        if (slave) begin
            tick = i_pair_wrap;
        end
        // Code zero names no source, so it never fires and always counts as enabled
        src_evt   = (cfg2_r.ssel != SSEL_NONE) & i_sync_events[cfg2_r.ssel];
        src_on    = (cfg2_r.ssel == SSEL_NONE) | i_source_enabled[cfg2_r.ssel];
        trig_mode = cfg2_r.trig;
        hw_set    = trig_mode ? src_evt : src_on;
        run       = slave ? i_pair_run : tstat_r;
    end

    // -------------------------------------------------------------
    // Control registers and trigger status
    // -------------------------------------------------------------
    // A trigger-event hardware set wins over a software write of zero
    always_comb begin
        cfg1_nxt  = cfg1_r;
        cfg2_nxt  = cfg2_r;
        tstat_nxt = trig_mode ? (tstat_r | hw_set) : hw_set;
        if (i_wr && i_addr == ADDR_CTRL1) begin
            cfg1_nxt.sidl = i_wdata[SIDL_BIT];
            cfg1_nxt.tsel = i_wdata[TSEL_LSB +: 3];
            cfg1_nxt.captures_per_interrupt  = i_wdata[ICI_LSB +: 2];
            cfg1_nxt.mode = i_wdata[MODE_LSB +: 3];
        end
        if (i_wr && i_addr == ADDR_CTRL2) begin
            cfg2_nxt.cascade = i_wdata[CASCADE_BIT];
            cfg2_nxt.trig    = i_wdata[TRIG_BIT];
            cfg2_nxt.ssel    = i_wdata[SSEL_LSB +: 5];
            // Only a trigger event may override the written value; the
            // sync-mode level takes over again on the next cycle
            tstat_nxt        = i_wdata[TSTAT_BIT] | (trig_mode & src_evt);
        end
    end

    // -------------------------------------------------------------
    // Dedicated counter
    // -------------------------------------------------------------
    always_comb begin
        cnt_nxt  = cnt_r;
        wrap_nxt = 1'b0;
        if (!run) begin
            cnt_nxt = 16'h0000;
        end else if (halted) begin
            cnt_nxt = cnt_r;
        end else if (!trig_mode && src_evt) begin
            cnt_nxt = 16'h0000;
        end else if (tick) begin
            cnt_nxt  = cnt_r + 16'h0001;
            wrap_nxt = (cnt_r == CNT_MAX);
        end
    end

    // -------------------------------------------------------------
    // Capture FIFO
    // -------------------------------------------------------------
    // A capture into a full FIFO is dropped unless a read frees a slot
    always_comb begin
        push     = cap_evt & (active | slave);
        pop      = i_rd & (i_addr == ADDR_FIFO) & (fill_r != 3'h0);
        full     = (fill_r == FIFO_DEPTH);
        ovf      = push & full & ~pop;
        store    = push & ~ovf;
        wp_nxt   = store ? wp_r + 2'h1 : wp_r;
        rp_nxt   = pop ? rp_r + 2'h1 : rp_r;
        fill_nxt = fill_r + {2'b00, store} - {2'b00, pop};
        for (int i = 0; i < 4; i++) begin
            mem_nxt[i] = (store && wp_r == i[1:0]) ? cnt_r : mem_r[i];
        end
        // Overflow clears when reads empty the FIFO; a new one wins
        ov_nxt = ov_r;
        if (fill_nxt == 3'h0) begin
            ov_nxt = 1'b0;
        end
        if (ovf) begin
            ov_nxt = 1'b1;
        end
    end

    // -------------------------------------------------------------
    // Interrupt pacing and wake
    // -------------------------------------------------------------
    always_comb begin
        ici_cnt_nxt = ici_cnt_r;
        irq_nxt     = 1'b0;
        if (!active || slave) begin
            ici_cnt_nxt = 2'h0;
        end else if (store) begin
            if (cfg1_r.mode == MODE_BOTH) begin
                irq_nxt = 1'b1;
            end else if (ici_cnt_r == cfg1_r.captures_per_interrupt) begin
                irq_nxt     = 1'b1;
                ici_cnt_nxt = 2'h0;
            end else begin
                ici_cnt_nxt = ici_cnt_r + 2'h1;
            end
        end
        wake_nxt = (cfg1_r.mode == MODE_WAKE) & (i_cpu_sleep | i_cpu_idle) & edge_rise;
        capo_nxt = store;
    end

    // -------------------------------------------------------------
    // Read port
    // -------------------------------------------------------------
    // Data stand one cycle after the strobe; unmapped words read zero
    always_comb begin
        rdata_nxt = 16'h0000;
        if (i_rd) begin
            case (i_addr)
                ADDR_CTRL1: begin
                    rdata_nxt[SIDL_BIT]        = cfg1_r.sidl;
                    rdata_nxt[TSEL_LSB +: 3]   = cfg1_r.tsel;
                    rdata_nxt[ICI_LSB +: 2]    = cfg1_r.captures_per_interrupt;
                    rdata_nxt[OV_BIT]          = ov_r;
                    rdata_nxt[BNE_BIT]         = (fill_r != 3'h0);
                    rdata_nxt[MODE_LSB +: 3]   = cfg1_r.mode;
                end
                ADDR_CTRL2: begin
                    rdata_nxt[CASCADE_BIT]     = cfg2_r.cascade;
                    rdata_nxt[TRIG_BIT]        = cfg2_r.trig;
                    rdata_nxt[TSTAT_BIT]       = tstat_r;
                    rdata_nxt[SSEL_LSB +: 5]   = cfg2_r.ssel;
                end
                ADDR_FIFO: rdata_nxt = pop ? mem_r[rp_r] : 16'h0000;
                default: rdata_nxt = 16'h0000;
            endcase
        end
    end

    // -------------------------------------------------------------
    // State registers
    // -------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            cfg1_r    <= icdt_cfg1_t'({CTRL1_RESET[SIDL_BIT], CTRL1_RESET[TSEL_LSB +: 3],
                                       CTRL1_RESET[ICI_LSB +: 2], CTRL1_RESET[MODE_LSB +: 3]});
            cfg2_r    <= icdt_cfg2_t'({CTRL2_RESET[CASCADE_BIT], CTRL2_RESET[TRIG_BIT],
                                       CTRL2_RESET[SSEL_LSB +: 5]});
            tstat_r   <= CTRL2_RESET[TSTAT_BIT];
            cnt_r     <= 16'h0000;
            wp_r      <= 2'h0;
            rp_r      <= 2'h0;
            fill_r    <= 3'h0;
            ov_r      <= 1'b0;
            ici_cnt_r <= 2'h0;
            rdata_r   <= 16'h0000;
            irq_r     <= 1'b0;
            wake_r    <= 1'b0;
            wrap_r    <= 1'b0;
            capo_r    <= 1'b0;
            run_r     <= 1'b0;
            for (int i = 0; i < 4; i++) begin
                mem_r[i] <= 16'h0000;
            end
        end else begin
            cfg1_r    <= cfg1_nxt;
            cfg2_r    <= cfg2_nxt;
            tstat_r   <= tstat_nxt;
            cnt_r     <= cnt_nxt;
            wp_r      <= wp_nxt;
            rp_r      <= rp_nxt;
            fill_r    <= fill_nxt;
            ov_r      <= ov_nxt;
            ici_cnt_r <= ici_cnt_nxt;
            rdata_r   <= rdata_nxt;
            irq_r     <= irq_nxt;
            wake_r    <= wake_nxt;
            wrap_r    <= wrap_nxt;
            capo_r    <= capo_nxt;
            run_r     <= run;
            for (int i = 0; i < 4; i++) begin
                mem_r[i] <= mem_nxt[i];
            end
        end
    end

    assign o_rdata       = rdata_r;
    assign o_capture_irq = irq_r;
    assign o_wake_irq    = wake_r;
    assign o_wrap        = wrap_r;
    assign o_capture     = capo_r;
    assign o_run         = run_r;

    // -------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_resetn);

    sequence s_last_pop;
        pop && fill_r == 3'h1 && !push;
    endsequence

    sequence s_full_push;
        push && full && !pop;
    endsequence

    fifo_depth_a: assert property (fill_r <= FIFO_DEPTH)
        else $error("fifo fill beyond four");
    mode_off_a: assert property ((cfg1_r.mode == MODE_OFF || cfg1_r.mode == MODE_UNUSED)
        && !slave |=> fill_r <= $past(fill_r))
        else $error("capture while module off");
    div4_gap_a: assert property (cfg1_r.mode == MODE_DIV4 && !slave && edge_cap
        |-> u_edge.pre_r == DIV4_LAST)
        else $error("div4 capture not on fourth edge");
    empty_flag_a: assert property (s_last_pop |=> fill_r == 3'h0
        && (!rdata_nxt[BNE_BIT] || !(i_rd && i_addr == ADDR_CTRL1)))
        else $error("not-empty flag stuck after drain");
    overflow_a: assert property (s_full_push |=> ov_r && fill_r == FIFO_DEPTH)
        else $error("overflow not flagged");
    oldest_first_a: assert property (pop |=> o_rdata == $past(mem_r[rp_r]))
        else $error("read did not return oldest entry");
    held_clear_a: assert property (!run |=> cnt_r == 16'h0000)
        else $error("counter not held clear");
    sync_reset_a: assert property (run && !halted && !trig_mode && src_evt
        |=> cnt_r == 16'h0000)
        else $error("sync event did not reset counter");
    idle_halt_a: assert property (run && halted |=> $stable(cnt_r))
        else $error("counter moved while halted");
    both_irq_a: assert property (active && !slave && store && cfg1_r.mode == MODE_BOTH
        |=> o_capture_irq)
        else $error("both-edge capture missed interrupt");
    wake_a: assert property (cfg1_r.mode == MODE_WAKE |=> !o_capture_irq)
        else $error("interrupt mode raised capture interrupt");

endmodule
`default_nettype wire

/* File: logic/icdt_pkg.sv */
// Constants, field layout and config carriers of the capture unit.
// Assumes a 16-bit register port with a two-bit word index.
package icdt_pkg;

    // -------------------------------------------------------------
    // Register map (word index)
    // -------------------------------------------------------------
    localparam logic [1:0]  ADDR_CTRL1  = 2'h0;
    localparam logic [1:0]  ADDR_CTRL2  = 2'h1;
    localparam logic [1:0]  ADDR_FIFO   = 2'h2;
    localparam logic [15:0] CTRL1_RESET = 16'h0000;
    localparam logic [15:0] CTRL2_RESET = 16'h000d;

    // -------------------------------------------------------------
    // Field positions
    // -------------------------------------------------------------
    localparam int SIDL_BIT    = 13;
    localparam int TSEL_LSB    = 10;
    localparam int ICI_LSB     = 5;
    localparam int OV_BIT      = 4;
    localparam int BNE_BIT     = 3;
    localparam int MODE_LSB    = 0;
    localparam int CASCADE_BIT = 8;
    localparam int TRIG_BIT    = 7;
    localparam int TSTAT_BIT   = 6;
    localparam int SSEL_LSB    = 0;

    // -------------------------------------------------------------
    // Encodings
    // -------------------------------------------------------------
    localparam logic [2:0]  MODE_OFF    = 3'h0;
    localparam logic [2:0]  MODE_BOTH   = 3'h1;
    localparam logic [2:0]  MODE_FALL   = 3'h2;
    localparam logic [2:0]  MODE_RISE   = 3'h3;
    localparam logic [2:0]  MODE_DIV4   = 3'h4;
    localparam logic [2:0]  MODE_DIV16  = 3'h5;
    localparam logic [2:0]  MODE_UNUSED = 3'h6;
    localparam logic [2:0]  MODE_WAKE   = 3'h7;
    localparam logic [2:0]  TSEL_SYSCLK = 3'h7;
    localparam logic [2:0]  TSEL_RSV_A  = 3'h6;
    localparam logic [2:0]  TSEL_RSV_B  = 3'h5;
    localparam logic [4:0]  SSEL_NONE   = 5'h00;
    localparam logic [3:0]  DIV4_LAST   = 4'h3;
    localparam logic [3:0]  DIV16_LAST  = 4'hf;
    localparam logic [15:0] CNT_MAX     = 16'hffff;
    localparam logic [2:0]  FIFO_DEPTH  = 3'h4;

    typedef struct packed {
        logic       sidl;
        logic [2:0] tsel;
        logic [1:0] captures_per_interrupt;
        logic [2:0] mode;
    } icdt_cfg1_t;

    typedef struct packed {
        logic       cascade;
        logic       trig;
        logic [4:0] ssel;
    } icdt_cfg2_t;

endpackage

/* File: logic/icdt_edge.sv */
// Edge detector and capture prescaler for the capture input pin.
// Assumes the pin is already synchronous to i_clock.
`timescale 1ns/1ps
`default_nettype none
module icdt_edge
    import icdt_pkg::*;
(
    input  wire logic       i_clock,
    input  wire logic       i_resetn,
    input  wire logic       i_pin,
    input  wire logic [2:0] i_mode,
    input  wire logic       i_enable,
    output logic            o_capture,
    output logic            o_rise
);
    logic       pin_d_r;
    logic       pin_d_nxt;
    logic [3:0] pre_r;
    logic [3:0] pre_nxt;
    logic       rise;
    logic       fall;
    logic [3:0] last;

    // -------------------------------------------------------------
    // Edge decode and prescale
    // -------------------------------------------------------------
    // Prescaler restarts whenever the unit is off, so the first
    // capture after enabling always needs a full count of edges
    always_comb begin
        pin_d_nxt = i_pin;
        rise      = i_pin & ~pin_d_r;
        fall      = ~i_pin & pin_d_r;
        last      = (i_mode == MODE_DIV4) ? DIV4_LAST : DIV16_LAST;
        pre_nxt   = pre_r;
        o_capture = 1'b0;
        if (!i_enable) begin
            pre_nxt = 4'h0;
        end else begin
            case (i_mode)
                MODE_BOTH: o_capture = rise | fall;
                MODE_FALL: o_capture = fall;
                MODE_RISE: o_capture = rise;
                MODE_DIV4, MODE_DIV16: begin
                    if (rise) begin
                        o_capture = (pre_r == last);
                        pre_nxt   = (pre_r == last) ? 4'h0 : pre_r + 4'h1;
                    end
                end
                default: o_capture = 1'b0;
            endcase
        end
        o_rise = rise;
    end

    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            pin_d_r <= 1'b0;
            pre_r   <= 4'h0;
        end else begin
            pin_d_r <= pin_d_nxt;
            pre_r   <= pre_nxt;
        end
    end

endmodule
`default_nettype wire

/* File: test/icdt_pulse_model.sv */
// Pulse source that stands on the capture input pin of the capture unit.
// Assumes the bench pulses i_start for one cycle after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module icdt_pulse_model (
    input  wire logic       i_clock,
    input  wire logic       i_resetn,
    input  wire logic       i_start,
    input  wire logic [7:0] i_edges,
    input  wire logic [7:0] i_gap,
    output logic            o_pin,
    output logic            o_busy
);
    // ---------------------------------------------------------
    // Toggle generator
    // ---------------------------------------------------------
    logic [7:0] left_r;
    logic [7:0] tmr_r;
    logic [7:0] gap_r;

    // One toggle per gap; a large gap mimics a slow source
    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            o_pin  <= 1'b0;
            left_r <= 8'h00;
            tmr_r  <= 8'h00;
            gap_r  <= 8'h00;
        end else if (i_start) begin
            left_r <= i_edges;
            tmr_r  <= i_gap;
            gap_r  <= i_gap;
        end else if (left_r != 8'h00) begin
            if (tmr_r <= 8'h01) begin
                o_pin  <= ~o_pin;
                left_r <= left_r - 8'h01;
                tmr_r  <= gap_r;
            end else begin
                tmr_r <= tmr_r - 8'h01;
            end
        end
    end

    // Busy while toggles remain to be sent
    assign o_busy = (left_r != 8'h00);
endmodule
`default_nettype wire

/* File: test/test_input_capture_dedicated_timer.sv */
// Self-checking bench of one capture unit driven by a pulse source model.
// Assumes a 100 MHz clock; pair inputs and timer ticks stay low.
`timescale 1ns/1ps
`default_nettype none
module test_input_capture_dedicated_timer;
    import icdt_pkg::*;
    logic        i_clock = 1'b0;
    logic        i_resetn = 1'b0;
    logic [1:0]  i_addr = 2'h0;
    logic [15:0] i_wdata = 16'h0000;
    logic        i_wr = 1'b0;
    logic        i_rd = 1'b0;
    logic [31:0] src_en = 32'h0000_0000;
    logic [31:0] sync_ev = 32'h0000_0000;
    logic        idle = 1'b0;
    logic        sleep = 1'b0;
    logic        start = 1'b0;
    logic [7:0]  edges = 8'h00;
    logic [7:0]  gap = 8'h00;
    logic        pin;
    logic        busy;
    logic [15:0] o_rdata;
    logic        o_capture_irq;
    logic        o_wake_irq;
    logic        o_capture;
    logic        o_run;
    int          err_total = 0;
    int          checked = 0;
    int          cap_n = 0;
    int          irq_n = 0;
    int          wake_n = 0;

    // Clock generation
    always #5 i_clock = ~i_clock;

    icdt_capture_unit #(.IS_EVEN(1'b0)) i_icdt_capture_unit (
        .i_clock(i_clock), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .i_capture_pin(pin), .i_time_base_ticks(5'h00),
        .i_sync_events(sync_ev), .i_source_enabled(src_en), .i_cpu_idle(idle),
        .i_cpu_sleep(sleep), .i_pair_wrap(1'b0), .i_pair_capture(1'b0), .i_pair_run(1'b0),
        .o_rdata(o_rdata), .o_capture_irq(o_capture_irq), .o_wake_irq(o_wake_irq),
        .o_wrap(), .o_capture(o_capture), .o_run(o_run));

    icdt_pulse_model i_icdt_pulse_model (
        .i_clock(i_clock), .i_resetn(i_resetn), .i_start(start), .i_edges(edges),
        .i_gap(gap), .o_pin(pin), .o_busy(busy));

    // Event counters; scenarios judge differences so history never matters
    always @(posedge i_clock) begin
        cap_n  <= cap_n + int'(o_capture === 1'b1);
        irq_n  <= irq_n + int'(o_capture_irq === 1'b1);
        wake_n <= wake_n + int'(o_wake_irq === 1'b1);
    end

    // ---------------------------------------------------------
    // Reporting
    // ---------------------------------------------------------
    task automatic end_of_test();
        $display("errors %0d of %0d comparisons", err_total, checked);
        if (err_total == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // ---------------------------------------------------------
    // Register port; every task is entered just after a rising edge
    // ---------------------------------------------------------
    task automatic wr(input logic [1:0] a, input logic [15:0] d);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_clock);
        i_wr <= 1'b0;
        @(posedge i_clock);
    endtask

    // Data stand only in the cycle after the strobe, sampled mid-cycle
    task automatic rd(input logic [1:0] a, output logic [15:0] d);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_clock);
        i_rd <= 1'b0;
        @(negedge i_clock);
        d = o_rdata;
        @(posedge i_clock);
    endtask

    function automatic logic [15:0] cfg(input logic s, input logic [1:0] captures_per_interrupt, input logic [2:0] m);
        cfg = 16'h0000;
        cfg[SIDL_BIT] = s;
        cfg[TSEL_LSB+:3] = TSEL_SYSCLK;
        cfg[ICI_LSB+:2] = captures_per_interrupt;
        cfg[MODE_LSB+:3] = m;
    endfunction

    // Pin toggles from the model; optional draining keeps the buffer shallow
    task automatic burst(input logic [7:0] n, input logic [7:0] g, input logic drain);
        logic [15:0] d;
        int          k;
        start <= 1'b1;
        edges <= n;
        gap   <= g;
        @(posedge i_clock);
        start <= 1'b0;
        @(posedge i_clock);
        for (k = 0; k < 4000 && busy; k++) begin
            if (drain) rd(ADDR_FIFO, d);
            else @(posedge i_clock);
        end
        repeat (4) @(posedge i_clock);
        if (drain) rd(ADDR_FIFO, d);
    endtask

    // ---------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------
    task automatic run_case(input logic s, input logic [1:0] captures_per_interrupt, input logic [2:0] m,
                            input logic [7:0] n, input int ec, input int ei, input int ew);
        int c0;
        int i0;
        int w0;
        wr(ADDR_CTRL1, cfg(1'b0, 2'b00, MODE_OFF));
        wr(ADDR_CTRL1, cfg(s, captures_per_interrupt, m));
        c0 = cap_n;
        i0 = irq_n;
        w0 = wake_n;
        burst(n, 8'd6, 1'b1);
        check("captures", 16'(ec), 16'(cap_n - c0));
        check("interrupts", 16'(ei), 16'(irq_n - i0));
        check("wakes", 16'(ew), 16'(wake_n - w0));
    endtask

    task automatic reset_and_sync();
        logic [15:0] d;
        rd(ADDR_CTRL1, d);
        check("ctrl1 reset", CTRL1_RESET, d);
        rd(ADDR_CTRL2, d);
        check("ctrl2 reset", CTRL2_RESET, d);
        check("held run", 16'h0000, {15'h0000, o_run});
        src_en <= 32'hffff_ffff;
        repeat (3) @(posedge i_clock);
        check("sync run", 16'h0001, {15'h0000, o_run});
        rd(ADDR_CTRL2, d);
        check("ctrl2 status", CTRL2_RESET | 16'h0040, d);
        wr(2'h3, 16'hffff);
        rd(2'h3, d);
        check("unmapped", 16'h0000, d);
        wr(ADDR_CTRL2, 16'h0000);
    endtask

    // Five rising edges into four places, then ordered readout
    task automatic overflow_order();
        logic [15:0] v [5];
        wr(ADDR_CTRL1, cfg(1'b0, 2'b00, MODE_OFF));
        wr(ADDR_CTRL1, cfg(1'b0, 2'b00, MODE_RISE));
        burst(8'd10, 8'd5, 1'b0);
        rd(ADDR_CTRL1, v[0]);
        check("flags full", cfg(1'b0, 2'b00, MODE_RISE) | 16'h0018, v[0]);
        for (int i = 1; i < 5; i++) rd(ADDR_FIFO, v[i]);
        for (int i = 2; i < 5; i++) check("spacing", 16'd10, v[i] - v[i-1]);
        rd(ADDR_CTRL1, v[0]);
        check("flags empty", cfg(1'b0, 2'b00, MODE_RISE), v[0]);
        wr(ADDR_CTRL1, cfg(1'b0, 2'b00, MODE_RISE) | 16'h0018);
        rd(ADDR_CTRL1, v[0]);
        check("flags ro", cfg(1'b0, 2'b00, MODE_RISE), v[0]);
    endtask

    // Sync event clears the counter; a trigger event releases it
    task automatic sync_source();
        logic [15:0] d;
        wr(ADDR_CTRL2, 16'h000d);
        wr(ADDR_CTRL1, cfg(1'b0, 2'b00, MODE_RISE));
        sync_ev <= 32'h0000_2000;
        start   <= 1'b1;
        edges   <= 8'd2;
        gap     <= 8'd20;
        @(posedge i_clock);
        sync_ev <= 32'h0000_0000;
        start   <= 1'b0;
        repeat (25) @(posedge i_clock);
        rd(ADDR_FIFO, d);
        check("sync stamp", 16'd20, d);
        wr(ADDR_CTRL2, 16'h008d);
        repeat (2) @(posedge i_clock);
        check("hw trig held", 16'h0000, {15'h0000, o_run});
        sync_ev <= 32'h0000_2000;
        @(posedge i_clock);
        sync_ev <= 32'h0000_0000;
        repeat (2) @(posedge i_clock);
        check("hw trig run", 16'h0001, {15'h0000, o_run});
    endtask

    // Software trigger: counter held until the status bit is written
    task automatic soft_trigger();
        logic [15:0] d;
        wr(ADDR_CTRL2, 16'h0080);
        repeat (2) @(posedge i_clock);
        check("trig held", 16'h0000, {15'h0000, o_run});
        wr(ADDR_CTRL2, 16'h00c0);
        rd(ADDR_CTRL2, d);
        check("trig status", 16'h00c0, d);
        check("trig run", 16'h0001, {15'h0000, o_run});
        wr(ADDR_CTRL2, 16'h0000);
    endtask

    // ---------------------------------------------------------
    // Main sequence and watchdog
    // ---------------------------------------------------------
    initial begin
        repeat (12) @(posedge i_clock);
        i_resetn <= 1'b1;
        @(posedge i_clock);
        reset_and_sync();
        run_case(1'b0, 2'b00, MODE_OFF, 8'd32, 0, 0, 0);
        run_case(1'b0, 2'b11, MODE_BOTH, 8'd32, 32, 32, 0);
        run_case(1'b0, 2'b00, MODE_FALL, 8'd32, 16, 16, 0);
        run_case(1'b0, 2'b00, MODE_RISE, 8'd24, 12, 12, 0);
        run_case(1'b0, 2'b01, MODE_RISE, 8'd24, 12, 6, 0);
        run_case(1'b0, 2'b10, MODE_RISE, 8'd24, 12, 4, 0);
        run_case(1'b0, 2'b11, MODE_RISE, 8'd24, 12, 3, 0);
        run_case(1'b0, 2'b00, MODE_DIV4, 8'd32, 4, 4, 0);
        run_case(1'b0, 2'b00, MODE_DIV16, 8'd32, 1, 1, 0);
        run_case(1'b0, 2'b00, MODE_UNUSED, 8'd32, 0, 0, 0);
        run_case(1'b0, 2'b00, MODE_WAKE, 8'd8, 0, 0, 0);
        idle <= 1'b1;
        run_case(1'b0, 2'b00, MODE_WAKE, 8'd8, 0, 0, 4);
        run_case(1'b1, 2'b00, MODE_RISE, 8'd8, 0, 0, 0);
        run_case(1'b0, 2'b00, MODE_RISE, 8'd8, 4, 4, 0);
        idle <= 1'b0;
        overflow_order();
        sync_source();
        soft_trigger();
        end_of_test();
    end

    // Whole run needs about 2300 cycles; give generous room
    initial begin
        repeat (50000) @(posedge i_clock);
        err_total++;
        end_of_test();
    end
endmodule
`default_nettype wire
